// ===== dv/irt_host.sv
// host model: drives the register port and watches the interrupt pins
module irt_host
    import irt_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // register port
    output irt_pkg::irt_req_t req,
    input wire logic [7:0] rdata,
    // interrupt pins
    input wire logic irq_pin_a,
    input wire logic irq_pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    int pin_events;
    initial req = '0;
    initial pin_events = 0;
    // servicing would read the source status, which lies outside this block
    always @(negedge irq_pin_a or negedge irq_pin_b) pin_events++;
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk_sys);
        req.wr = 1'b0;
    endtask : write_reg
    // read data is registered, so it lands one edge after the address
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        req.addr = a;
        @(negedge clk_sys);
        d = rdata;
    endtask : read_reg
endmodule : irt_host

// ===== dv/tb_irt_top.sv
// testbench: register access, pin routing and trim correction
module tb_irt_top;
    timeunit 1ns;
    timeprecision 1ps;
    import irt_pkg::*;
    logic clk_sys, rstn, ce, irq_pin_a, irq_pin_b;
    logic [7:0] evt, rdata;
    irt_req_t req;
    irt_meas_t meas_raw, meas_out;
    int bad_count = 0, compares = 0, cycles = 0;
    logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'hC3, 8'hFF};
    irt_top irt_top_i (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .req(req), .rdata(rdata),
        .evt(evt), .meas_raw(meas_raw), .meas_out(meas_out), .irq_pin_a(irq_pin_a),
        .irq_pin_b(irq_pin_b));
    irt_host irt_host_i (.clk_sys(clk_sys), .req(req), .rdata(rdata), .irq_pin_a(irq_pin_a),
        .irq_pin_b(irq_pin_b));
    always #5 clk_sys = ~clk_sys;
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    // generous ceiling; the sequence needs about 110 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            complete_run();
        end
    end
    initial begin
        logic [7:0] d;
        clk_sys = 1'b0;
        rstn = 1'b0;
        ce = 1'b1;
        evt = 8'h00;
        meas_raw = '0;
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        check("pin_a idle", 1, irq_pin_a);
        check("pin_b idle", 1, irq_pin_b);
        for (int i = 0; i < 4; i++) begin
            irt_host_i.read_reg(IRT_ADDR_ROUTE + 8'(i), d);
            check("reset value", 0, d);
        end
        // reserved slot must ignore the write
        for (int i = 0; i < 4; i++) begin
            irt_host_i.write_reg(IRT_ADDR_ROUTE + 8'(i), pat[i]);
        end
        for (int i = 0; i < 4; i++) begin
            irt_host_i.read_reg(IRT_ADDR_ROUTE + 8'(i), d);
            check("readback", (i == 3) ? 8'h00 : pat[i], d);
        end
        $display("test registers done");
        irt_host_i.write_reg(IRT_ADDR_ENABLE, 8'hFF);
        for (int i = 0; i < 8; i++) begin
            for (int r = 0; r < 2; r++) begin
                irt_host_i.write_reg(IRT_ADDR_ROUTE, (r == 1) ? (8'h01 << i) : 8'h00);
                evt = 8'h01 << i;
                @(negedge clk_sys);
                check("route pin_a", (r == 1) ? 0 : 1, irq_pin_a);
                check("route pin_b", (r == 1) ? 1 : 0, irq_pin_b);
                evt = 8'h00;
            end
        end
        $display("test routing done");
        irt_host_i.write_reg(IRT_ADDR_ROUTE, 8'h01);
        evt = 8'h03;
        @(negedge clk_sys);
        check("or pin_a", 0, irq_pin_a);
        check("or pin_b", 0, irq_pin_b);
        // events stand while the routing changes: pins follow at the write edge
        irt_host_i.write_reg(IRT_ADDR_ROUTE, 8'h03);
        check("reroute at once", 2'b01, {irq_pin_a, irq_pin_b});
        irt_host_i.write_reg(IRT_ADDR_ROUTE, 8'h01);
        check("reroute back", 2'b00, {irq_pin_a, irq_pin_b});
        irt_host_i.write_reg(IRT_ADDR_ENABLE, 8'h00);
        @(negedge clk_sys);
        check("disabled pins", 2'b11, {irq_pin_a, irq_pin_b});
        irt_host_i.write_reg(IRT_ADDR_ENABLE, 8'hFF);
        irt_host_i.write_reg(IRT_ADDR_POLARITY, 8'h22);
        @(negedge clk_sys);
        check("active high pins", 2'b11, {irq_pin_a, irq_pin_b});
        evt = 8'h00;
        @(negedge clk_sys);
        check("idle high pol", 2'b00, {irq_pin_a, irq_pin_b});
        // only the two polarity bits are kept; holes in the map read zero
        irt_host_i.write_reg(IRT_ADDR_POLARITY, 8'hFF);
        irt_host_i.read_reg(IRT_ADDR_POLARITY, d);
        check("polarity bits", 8'h22, d);
        irt_host_i.read_reg(IRT_ADDR_ENABLE, d);
        check("enable readback", 8'hFF, d);
        irt_host_i.read_reg(8'h2E, d);
        check("unmapped read", 8'h00, d);
        $display("test or, enable, polarity done");
        irt_host_i.write_reg(IRT_ADDR_PTRIM, 8'hFF);
        irt_host_i.write_reg(IRT_ADDR_TTRIM, 8'h80);
        meas_raw = '{valid: 1'b1, pres: 20'h003E8, temp: 12'h0C8};
        @(negedge clk_sys);
        check("pres trimmed", 20'h003E4, meas_out.pres);
        check("temp trimmed", 12'h048, meas_out.temp);
        check("meas valid", 1, meas_out.valid);
        $display("test trim done");
        // clock enable low: a write is ignored and the outputs hold
        ce = 1'b0;
        meas_raw.pres = 20'h00010;
        irt_host_i.write_reg(IRT_ADDR_PTRIM, 8'h11);
        check("pres held", 20'h003E4, meas_out.pres);
        ce = 1'b1;
        irt_host_i.read_reg(IRT_ADDR_PTRIM, d);
        check("trim kept", 8'hFF, d);
        check("host saw pins", 1, irt_host_i.pin_events > 0);
        $display("test clock enable done");
        complete_run();
    end
endmodule : tb_irt_top

// ===== shared/irt_pkg.sv
// package: register map, field layout and carrier types of the interrupt routing and trim block
package irt_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] IRT_ADDR_POLARITY = 8'h28;
    localparam logic [7:0] IRT_ADDR_ENABLE = 8'h29;
    localparam logic [7:0] IRT_ADDR_ROUTE = 8'h2A;
    localparam logic [7:0] IRT_ADDR_PTRIM = 8'h2B;
    localparam logic [7:0] IRT_ADDR_TTRIM = 8'h2C;
    localparam logic [7:0] IRT_ADDR_RSVD = 8'h2D;
    // ****************************************
    // reset values and fields
    // ****************************************
    localparam logic [7:0] IRT_RST_ROUTE = 8'h00;
    localparam logic [7:0] IRT_RST_ENABLE = 8'h00;
    localparam logic [7:0] IRT_RST_TRIM = 8'h00;
    localparam logic [7:0] IRT_RST_POL = 8'h00;
    localparam logic [7:0] IRT_RSVD_VALUE = 8'h00;
    localparam int IRT_POL_A_BIT = 5;
    localparam int IRT_POL_B_BIT = 1;
    localparam logic [7:0] IRT_POL_WMASK = 8'h22;
    localparam int IRT_NSRC = 8;
    // trim scaling: pressure 4 Pa/LSB, temperature 1/16 degC/LSB
    localparam int IRT_PTRIM_SHIFT = 2;
    localparam int IRT_P_W = 20;
    localparam int IRT_T_W = 12;

    // register write/read port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } irt_req_t;

    // raw and corrected measurements; pressure in Pa, temperature in 1/16 degC
    typedef struct packed {
        logic valid;
        logic [IRT_P_W-1:0] pres;
        logic [IRT_T_W-1:0] temp;
    } irt_meas_t;
endpackage : irt_pkg

// ===== verilog/irt_top.sv
// module: interrupt pin routing and output offset trim
// Contract
// - routing bit 0 to pin b, 1 to pin a
// - routing register at 2Ah, eight source bits
// - routing bits reset to zero
// - events on one pin are ORed
// - pressure trim signed, 4 Pa per lsb
// - temperature trim signed, 0.0625 degC per lsb
// - trims at 2Bh, 2Ch, read/write, reset zero
// - trims correct reported pressure and temperature
// - 2Dh reserved, reads zero
// - disabled sources never assert a pin
// - pin polarity default active low
module irt_top
    import irt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic ce,
    // register port
    input wire irt_pkg::irt_req_t req,
    output logic [7:0] rdata,
    // event sources, same clock
    input wire logic [7:0] evt,
    // measurements
    input wire irt_pkg::irt_meas_t meas_raw,
    output irt_pkg::irt_meas_t meas_out,
    // interrupt pins
    output logic irq_pin_a,
    output logic irq_pin_b
);
    import irt_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] irq_pin_route_select_r;
    logic [7:0] irq_source_enable_r;
    logic [7:0] pin_polarity_select_r;
    logic [7:0] pressure_offset_trim_r;
    logic [7:0] temperature_offset_trim_r;
    logic [7:0] rdata_nxt;
    logic irq_a_nxt;
    logic irq_b_nxt;

    function automatic logic hit(input irt_req_t r, input logic [7:0] a);
        hit = r.wr && (r.addr == a);
    endfunction : hit

    wire logic wr_route = hit(req, IRT_ADDR_ROUTE);
    wire logic wr_en = hit(req, IRT_ADDR_ENABLE);
    wire logic wr_pol = hit(req, IRT_ADDR_POLARITY);
    wire logic wr_pt = hit(req, IRT_ADDR_PTRIM);
    wire logic wr_tt = hit(req, IRT_ADDR_TTRIM);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            irq_pin_route_select_r <= IRT_RST_ROUTE;
            irq_source_enable_r <= IRT_RST_ENABLE;
            pin_polarity_select_r <= IRT_RST_POL;
            pressure_offset_trim_r <= IRT_RST_TRIM;
            temperature_offset_trim_r <= IRT_RST_TRIM;
        end else if (ce) begin
            if (wr_route) irq_pin_route_select_r <= req.wdata;
            if (wr_en) irq_source_enable_r <= req.wdata;
            if (wr_pol) pin_polarity_select_r <= req.wdata & IRT_POL_WMASK;
            if (wr_pt) pressure_offset_trim_r <= req.wdata;
            if (wr_tt) temperature_offset_trim_r <= req.wdata;
        end
    end

    // ****************************************
    // read decode
    // ****************************************
    always_comb begin
        case (req.addr)
            IRT_ADDR_POLARITY: rdata_nxt = pin_polarity_select_r;
            IRT_ADDR_ENABLE: rdata_nxt = irq_source_enable_r;
            IRT_ADDR_ROUTE: rdata_nxt = irq_pin_route_select_r;
            IRT_ADDR_PTRIM: rdata_nxt = pressure_offset_trim_r;
            IRT_ADDR_TTRIM: rdata_nxt = temperature_offset_trim_r;
            IRT_ADDR_RSVD: rdata_nxt = IRT_RSVD_VALUE;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // ****************************************
    // routing
    // ****************************************
    // routing from the written value in the same cycle, so a write acts at once
    wire logic [7:0] route_eff = wr_route ? req.wdata : irq_pin_route_select_r;
    wire logic [7:0] ev_on = evt & irq_source_enable_r;
    wire logic [7:0] to_a;
    wire logic [7:0] to_b;
    genvar g;
    generate
        for (g = 0; g < IRT_NSRC; g++) begin : g_route
            assign to_a[g] = ev_on[g] & route_eff[g];
            assign to_b[g] = ev_on[g] & ~route_eff[g];
        end
    endgenerate
    wire logic act_a = |to_a;
    wire logic act_b = |to_b;
    // pin level: active low unless polarity bit set
    assign irq_a_nxt = pin_polarity_select_r[IRT_POL_A_BIT] ? act_a : ~act_a;
    assign irq_b_nxt = pin_polarity_select_r[IRT_POL_B_BIT] ? act_b : ~act_b;

    // ****************************************
    // trim
    // ****************************************
    wire logic [IRT_P_W-1:0] p_corr;
    wire logic [IRT_T_W-1:0] t_corr;
    irt_trim_add #(.W(IRT_P_W), .SHIFT(IRT_PTRIM_SHIFT)) u_ptrim (
        .raw(meas_raw.pres),
        .trim(pressure_offset_trim_r),
        .sum(p_corr)
    );
    irt_trim_add #(.W(IRT_T_W), .SHIFT(0)) u_ttrim (
        .raw(meas_raw.temp),
        .trim(temperature_offset_trim_r),
        .sum(t_corr)
    );

    // ****************************************
    // output flops
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata <= 8'h00;
            irq_pin_a <= 1'b1;
            irq_pin_b <= 1'b1;
            meas_out <= '0;
        end else if (ce) begin
            rdata <= rdata_nxt;
            irq_pin_a <= irq_a_nxt;
            irq_pin_b <= irq_b_nxt;
            meas_out <= '{valid: meas_raw.valid, pres: p_corr, temp: t_corr};
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    property p_route_b;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && (evt & irq_source_enable_r & ~route_eff) != 8'h00 && !pin_polarity_select_r[1])
        |=> !irq_pin_b;
    endproperty
    a_route_b: assert property (p_route_b) else $error("pin b not asserted");
    property p_route_a;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && (evt & irq_source_enable_r & route_eff) != 8'h00 && pin_polarity_select_r[5])
        |=> irq_pin_a;
    endproperty
    a_route_a: assert property (p_route_a) else $error("pin a not asserted");
    property p_reset_route;
        @(posedge clk_sys) !rstn |=> irq_pin_route_select_r == 8'h00;
    endproperty
    a_reset_route: assert property (p_reset_route) else $error("route not reset");
    property p_wr_route;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && wr_route) |=> irq_pin_route_select_r == $past(req.wdata);
    endproperty
    a_wr_route: assert property (p_wr_route) else $error("route write lost");
    property p_disabled;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && (evt & irq_source_enable_r) == 8'h00 && pin_polarity_select_r == 8'h00)
        |=> irq_pin_a && irq_pin_b;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled source drove pin");
    property p_rsvd;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && req.addr == IRT_ADDR_RSVD) |=> rdata == 8'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read nonzero");
    property p_ptrim;
        @(posedge clk_sys) disable iff (!rstn)
        ce |=> meas_out.pres == $past(meas_raw.pres)
            + IRT_P_W'($signed($past(pressure_offset_trim_r)) * 4);
    endproperty
    a_ptrim: assert property (p_ptrim) else $error("pressure trim wrong");
    property p_ttrim;
        @(posedge clk_sys) disable iff (!rstn)
        ce |=> meas_out.temp == $past(meas_raw.temp)
            + IRT_T_W'($signed($past(temperature_offset_trim_r)));
    endproperty
    a_ttrim: assert property (p_ttrim) else $error("temperature trim wrong");
    // a route write steers the pins at its own edge, not one edge later
    property p_reroute;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && wr_route && (evt & irq_source_enable_r & req.wdata) != 8'h00
            && !pin_polarity_select_r[IRT_POL_A_BIT])
        |=> !irq_pin_a;
    endproperty
    a_reroute: assert property (p_reroute) else $error("route write acted late");
    property p_reroute_b;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && wr_route && (evt & irq_source_enable_r & ~req.wdata) != 8'h00
            && !pin_polarity_select_r[IRT_POL_B_BIT])
        |=> !irq_pin_b;
    endproperty
    a_reroute_b: assert property (p_reroute_b) else $error("route write acted late");
    // ****************************************
    // clock enable and read decode checks
    // ****************************************
    // ce low must freeze the outputs, the routing register and the pressure trim
    property p_hold;
        @(posedge clk_sys) disable iff (!rstn)
        !ce |=> $stable(rdata) && $stable(irq_pin_a) && $stable(irq_pin_b)
            && $stable(meas_out) && $stable(irq_pin_route_select_r)
            && $stable(pressure_offset_trim_r);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while clock enable low");
    // holes in the map read as zero
    property p_unmapped;
        @(posedge clk_sys) disable iff (!rstn)
        (ce && (req.addr < IRT_ADDR_POLARITY || req.addr > IRT_ADDR_RSVD))
        |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    c_both: cover property (@(posedge clk_sys) disable iff (!rstn) !irq_pin_a && !irq_pin_b);
    c_reroute: cover property (@(posedge clk_sys) disable iff (!rstn) wr_route && |evt);
    c_neg: cover property (@(posedge clk_sys) disable iff (!rstn) pressure_offset_trim_r[7]);
    c_frozen_wr: cover property (@(posedge clk_sys) disable iff (!rstn) !ce && req.wr);
    c_pol_high: cover property (@(posedge clk_sys) disable iff (!rstn) pin_polarity_select_r[5]);
endmodule : irt_top

// ===== verilog/irt_trim_add.sv
// module: signed offset trim adder for one measurement word
module irt_trim_add #(
    parameter int W = 12,
    parameter int SHIFT = 0
) (
    // operands
    input wire logic [W-1:0] raw,
    input wire logic [7:0] trim,
    // result
    output logic [W-1:0] sum
);
    // sign extend, then scale by the lsb weight
    wire logic [W-1:0] trim_ext;
    assign trim_ext = W'($signed({{(W-8){trim[7]}}, trim}) <<< SHIFT);
    assign sum = raw + trim_ext;
endmodule : irt_trim_add
